/* rtl/wake_defs.svh */
// Purpose: Constants of the wake-up event control block
// Assumes: 32-bit register port, byte offsets in 8 bits
// Notes:   Types live in wake_pkg
`ifndef WAKE_DEFS_SVH
`define WAKE_DEFS_SVH

// Register byte offsets
`define OFF_WAKE_CS      8'h68
`define OFF_WAKE_PAT     8'h70
`define OFF_IRQ_STATUS   8'h40
`define OFF_IRQ_MASK     8'h44
`define OFF_PAT_PTR      8'h48

// Control and status field positions
`define CS_CRC_SEL       30
`define CS_PAT1_EN       29
`define CS_LINK_OFF_EN   17
`define CS_LINK_ON_EN    16
`define CS_FRAME_EN      10
`define CS_SIG_EN        9
`define CS_LINK_EN       8
`define CS_FRAME_SEEN    2
`define CS_SIG_SEEN      1
`define CS_LINK_SEEN     0

// Event vector positions (status, irq status and mask share them)
`define EV_FRAME         2
`define EV_SIG           1
`define EV_LINK          0

// Pattern store
`define PAT_WORDS        25
`define PAT_LAST         5'h18
`define PAT_STRIDE       5
`define PTR_ZERO         5'h00
`define CRC_MSB          31
`define CRC_LSB          16
`define OFS_MSB          7

// CRC seeds
`define CRC_ZEROS        16'h0000
`define CRC_ONES         16'hffff

// Strap capture after reset release
`define INIT_LOAD        2'h2
`define INIT_DONE        2'h3

// Reset values
`define RST_WORD         32'h0000_0000
`define RST_EV           3'h0
`define RST_EN5          5'h00
`define RST_CNT          2'h0

`endif

/* rtl/wake_pkg.sv */
// Purpose: Types of the wake-up event control block
// Assumes: wake_defs.svh supplies sizes
// Notes:   Filter struct packs mask above CRC above offset
`include "wake_defs.svh"

package wake_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_type;

	typedef struct packed {
		logic [127:0] mask;
		logic [15:0]  crc;
		logic [7:0]   start;
	} filter_type;

	typedef struct packed {
		logic [`PAT_WORDS-1:0][31:0] words;
		logic [4:0]                  ptr;
		logic                        crc_sel;
		logic [4:0]                  pat_en;
		logic                        link_off_en;
		logic                        link_on_en;
		logic                        frame_en;
		logic                        sig_en;
		logic                        link_en;
		logic [2:0]                  seen;
		logic [2:0]                  irq_status;
		logic [2:0]                  irq_mask;
		logic                        irq;
		logic                        pm_event;
		logic [15:0]                 crc_init;
		logic [31:0]                 rdata;
		logic                        link_s1;
		logic                        link_s2;
		logic                        link_prev;
		logic                        pm_s1;
		logic                        pm_s2;
		logic                        wol_s1;
		logic                        wol_s2;
		logic [1:0]                  init_cnt;
	} wake_state_type;

endpackage

/* rtl/wake_event_control.sv */
// Purpose: Wake-up control, status and pattern filter store
// Assumes: Event inputs come from logic on clk_sys; pins are synchronised
// Notes:   reset_n is power-up reset; soft_reset spares the seen flags
//
// Chosen here: the strobed register port.
`timescale 1ns/1ns
`include "wake_defs.svh"

module wake_event_control (
	input  wire logic                     clk_sys,
	input  wire logic                     reset_n,
	input  wire logic                     soft_reset,
	input  wire wake_pkg::bus_req_type    reg_req,
	output logic      [31:0]              reg_rdata,
	input  wire logic                     link_up,
	input  wire logic                     power_mgmt_cfg,
	input  wire logic                     wake_lan_cfg,
	input  wire logic                     sig_packet_rx,
	input  wire logic [4:0]               pattern_match,
	output wake_pkg::filter_type [4:0]    filters,
	output logic      [15:0]              crc_init_value,
	output logic                          pm_event_set,
	output logic                          irq
);
	import wake_pkg::*;

	wake_state_type state;
	wake_state_type next_state;
	logic           init_done;
	logic           link_rise;
	logic           link_fall;
	logic           link_ev;
	logic           sig_ev;
	logic           frame_ev;
	logic [2:0]     events;
	logic           cs_wr;
	logic [2:0]     cs_clear;
	logic [2:0]     irq_clear;

	// Event detection
	assign init_done = (state.init_cnt == `INIT_DONE);
	assign link_rise = init_done & state.link_s2 & ~state.link_prev;
	assign link_fall = init_done & ~state.link_s2 & state.link_prev;
	assign link_ev   = (link_rise & state.link_on_en)
		| (link_fall & state.link_off_en);
	assign sig_ev    = sig_packet_rx;
	assign frame_ev  = |(pattern_match & state.pat_en);
	assign events    = {frame_ev, sig_ev, link_ev};

	// Write-one clear strobes
	assign cs_wr     = reg_req.wr & (reg_req.addr == `OFF_WAKE_CS);
	assign cs_clear  = cs_wr ? reg_req.wdata[2:0] : `RST_EV;
	assign irq_clear = (reg_req.wr & (reg_req.addr == `OFF_IRQ_STATUS))
		? reg_req.wdata[2:0] : `RST_EV;

	always_comb begin
		next_state = state;
		next_state.link_s1 = link_up;
		next_state.link_s2 = state.link_s1;
		next_state.pm_s1   = power_mgmt_cfg;
		next_state.pm_s2   = state.pm_s1;
		next_state.wol_s1  = wake_lan_cfg;
		next_state.wol_s2  = state.wol_s1;
		next_state.rdata   = `RST_WORD;

		// Strap capture once the synchronisers hold the pin levels
		if (!init_done) begin
			next_state.init_cnt = state.init_cnt + 2'h1;
			if (state.init_cnt == `INIT_LOAD) begin
				next_state.sig_en    = state.pm_s2 & state.wol_s2;
				next_state.link_prev = state.link_s2;
			end
		end else begin
			next_state.link_prev = state.link_s2;
		end

		// Sticky flags, set wins over clear
		next_state.seen = (state.seen & ~cs_clear) | events;
		next_state.irq_status = (state.irq_status & ~irq_clear) | events;

		// Wake event toward the power management register
		next_state.pm_event = (frame_ev & state.frame_en)
			| (sig_ev & state.sig_en)
			| (link_ev & state.link_en);

		// Register writes
		if (reg_req.wr) begin
			unique case (reg_req.addr)
			`OFF_WAKE_CS: begin
				next_state.crc_sel     = reg_req.wdata[`CS_CRC_SEL];
				for (int p = 0; p < 5; p++) begin
					next_state.pat_en[p] = reg_req.wdata[`CS_PAT1_EN - p];
				end
				next_state.link_off_en = reg_req.wdata[`CS_LINK_OFF_EN];
				next_state.link_on_en  = reg_req.wdata[`CS_LINK_ON_EN];
				next_state.frame_en    = reg_req.wdata[`CS_FRAME_EN];
				next_state.sig_en      = reg_req.wdata[`CS_SIG_EN];
				next_state.link_en     = reg_req.wdata[`CS_LINK_EN];
			end
			`OFF_WAKE_PAT: begin
				next_state.words[state.ptr] = reg_req.wdata;
			end
			`OFF_IRQ_MASK: begin
				next_state.irq_mask = reg_req.wdata[2:0];
			end
			`OFF_PAT_PTR: begin
				next_state.ptr = `PTR_ZERO;
			end
			default: begin
			end
			endcase
		end

		// Register reads, data stand in the following cycle
		if (reg_req.rd) begin
			unique case (reg_req.addr)
			`OFF_WAKE_CS: begin
				next_state.rdata[`CS_CRC_SEL] = state.crc_sel;
				for (int p = 0; p < 5; p++) begin
					next_state.rdata[`CS_PAT1_EN - p] = state.pat_en[p];
				end
				next_state.rdata[`CS_LINK_OFF_EN] = state.link_off_en;
				next_state.rdata[`CS_LINK_ON_EN]  = state.link_on_en;
				next_state.rdata[`CS_FRAME_EN]    = state.frame_en;
				next_state.rdata[`CS_SIG_EN]      = state.sig_en;
				next_state.rdata[`CS_LINK_EN]     = state.link_en;
				next_state.rdata[2:0]             = state.seen;
			end
			`OFF_WAKE_PAT: begin
				next_state.rdata = state.words[state.ptr];
			end
			`OFF_IRQ_STATUS: begin
				next_state.rdata[2:0] = state.irq_status;
			end
			`OFF_IRQ_MASK: begin
				next_state.rdata[2:0] = state.irq_mask;
			end
			`OFF_PAT_PTR: begin
				next_state.rdata[4:0] = state.ptr;
			end
			default: begin
			end
			endcase
		end

		// Sequential word pointer wraps after the last of 25 words
		if ((reg_req.wr | reg_req.rd) && (reg_req.addr == `OFF_WAKE_PAT)) begin
			if (state.ptr == `PAT_LAST) begin
				next_state.ptr = `PTR_ZERO;
			end else begin
				next_state.ptr = state.ptr + 5'h01;
			end
		end

		// Software reset spares the seen flags; reset_n clears them
		if (soft_reset) begin
			next_state.crc_sel     = 1'b0;
			next_state.pat_en      = `RST_EN5;
			next_state.link_off_en = 1'b0;
			next_state.link_on_en  = 1'b0;
			next_state.frame_en    = 1'b0;
			next_state.sig_en      = 1'b0;
			next_state.link_en     = 1'b0;
			next_state.irq_status  = `RST_EV;
			next_state.irq_mask    = `RST_EV;
			next_state.ptr         = `PTR_ZERO;
			next_state.pm_event    = 1'b0;
			next_state.init_cnt    = `RST_CNT;
		end

		next_state.irq = |(next_state.irq_status & next_state.irq_mask);
		next_state.crc_init = next_state.crc_sel
			? `CRC_ONES : `CRC_ZEROS;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	// Filter view of the pattern words
	generate
		for (genvar p = 0; p < 5; p++) begin : g_filter
			assign filters[p].mask = {
				state.words[`PAT_STRIDE*p+3],
				state.words[`PAT_STRIDE*p+2],
				state.words[`PAT_STRIDE*p+1],
				state.words[`PAT_STRIDE*p]};
			assign filters[p].crc =
				state.words[`PAT_STRIDE*p+4][`CRC_MSB:`CRC_LSB];
			assign filters[p].start =
				state.words[`PAT_STRIDE*p+4][`OFS_MSB:0];
		end
	endgenerate

	assign reg_rdata      = state.rdata;
	assign crc_init_value = state.crc_init;
	assign pm_event_set   = state.pm_event;
	assign irq            = state.irq;

	// Checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!reset_n);

	sig_wake_event_a: assert property (
		sig_packet_rx && state.sig_en && !soft_reset |=> pm_event_set)
		else $error("signature packet did not raise wake event");

	link_wake_event_a: assert property (
		link_ev && !state.link_en && !frame_ev && !sig_ev |=> !pm_event_set)
		else $error("disabled link change raised wake event");

	frame_seen_set_a: assert property (
		frame_ev |=> state.seen[`EV_FRAME])
		else $error("wake frame flag not set");

	sig_seen_keep_a: assert property (
		state.seen[`EV_SIG] && !cs_clear[`EV_SIG] |=> state.seen[`EV_SIG])
		else $error("signature flag lost without clear");

	link_seen_set_a: assert property (
		link_ev || (state.seen[`EV_LINK] && soft_reset && !cs_clear[`EV_LINK])
		|=> state.seen[`EV_LINK])
		else $error("link flag not set or lost over soft reset");

	mask_load_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == 5'h03
		&& !soft_reset |=> filters[0].mask[127:96] == $past(reg_req.wdata))
		else $error("mask word landed in wrong place");

	second_block_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == 5'h05
		&& !soft_reset |=> filters[1].mask[31:0] == $past(reg_req.wdata))
		else $error("second pattern block misplaced");

	crc_word_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == 5'h04
		&& !soft_reset |=> filters[0].crc == $past(reg_req.wdata[31:16])
		&& filters[0].start == $past(reg_req.wdata[7:0]))
		else $error("CRC or start offset misplaced");

	ptr_wrap_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == `PAT_LAST
		|=> state.ptr == `PTR_ZERO)
		else $error("pointer did not wrap after 25 words");

	crc_seed_a: assert property (
		cs_wr && reg_req.wdata[`CS_CRC_SEL] && !soft_reset
		|=> crc_init_value == `CRC_ONES)
		else $error("CRC seed not all ones");

	pattern_gate_a: assert property (
		!state.seen[`EV_FRAME] && (pattern_match & state.pat_en) == 5'h00
		|=> !state.seen[`EV_FRAME])
		else $error("disabled pattern set wake frame flag");

	irq_follow_a: assert property (
		irq |-> |(state.irq_status & state.irq_mask))
		else $error("interrupt without unmasked status");

	// Flag, enable, pointer, read data, interrupt, CRC seed and filter checks
	sig_seen_set_a: assert property (
		sig_packet_rx
		|=> state.seen[`EV_SIG])
		else $error("signature flag not set");

	link_wake_on_a: assert property (
		link_ev && state.link_en && !soft_reset
		|=> pm_event_set)
		else $error("enabled link change gave no wake event");

	frame_wake_a: assert property (
		frame_ev && state.frame_en && !soft_reset
		|=> pm_event_set)
		else $error("enabled wake frame gave no wake event");

	pm_cause_a: assert property (
		pm_event_set
		|-> $past(frame_ev || sig_ev || link_ev))
		else $error("wake event without a cause");

	seen_clear_a: assert property (
		cs_wr && events == `RST_EV
		|=> (state.seen & $past(reg_req.wdata[2:0])) == `RST_EV)
		else $error("seen flag not cleared by write of one");

	soft_keeps_seen_a: assert property (
		soft_reset && cs_clear == `RST_EV
		|=> ($past(state.seen) & ~state.seen) == `RST_EV)
		else $error("soft reset cleared a seen flag");

	soft_clears_en_a: assert property (
		soft_reset
		|=> !state.link_en && !state.sig_en && !pm_event_set)
		else $error("soft reset left a wake enable set");

	sig_en_default_a: assert property (
		state.init_cnt == `INIT_LOAD && !soft_reset && !cs_wr
		|=> state.sig_en == $past(state.pm_s2 && state.wol_s2))
		else $error("signature enable default not loaded");

	ptr_step_a: assert property (
		(reg_req.wr || reg_req.rd) && reg_req.addr == `OFF_WAKE_PAT
		&& state.ptr != `PAT_LAST && !soft_reset
		|=> state.ptr == $past(state.ptr) + 5'h01)
		else $error("pattern pointer did not step");

	rdata_idle_a: assert property (
		!reg_req.rd
		|=> reg_rdata == `RST_WORD)
		else $error("read data outside read cycle");

	irq_set_a: assert property (
		(events & state.irq_mask) != `RST_EV && !soft_reset
		&& !(reg_req.wr && reg_req.addr == `OFF_IRQ_MASK)
		|=> irq)
		else $error("unmasked event gave no interrupt");

	irq_clear_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_IRQ_STATUS && events == `RST_EV
		|=> (state.irq_status & $past(reg_req.wdata[2:0])) == `RST_EV)
		else $error("interrupt status not cleared by write of one");

	crc_zero_a: assert property (
		cs_wr && !reg_req.wdata[`CS_CRC_SEL]
		|=> crc_init_value == `CRC_ZEROS)
		else $error("CRC seed not all zeros");

	mask_low_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == `PTR_ZERO
		|=> filters[0].mask[31:0] == $past(reg_req.wdata))
		else $error("first mask word landed in wrong place");

	last_crc_a: assert property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == `PAT_LAST
		|=> filters[4].crc == $past(reg_req.wdata[`CRC_MSB:`CRC_LSB])
		&& filters[4].start == $past(reg_req.wdata[`OFS_MSB:0]))
		else $error("fifth pattern CRC or offset misplaced");

	soft_keep_c: cover property (soft_reset && state.seen != `RST_EV);
	strap_load_c: cover property (
		state.init_cnt == `INIT_LOAD ##1 state.sig_en);

	full_load_c: cover property (
		reg_req.wr && reg_req.addr == `OFF_WAKE_PAT && state.ptr == `PAT_LAST);
	link_event_c: cover property (link_ev && state.link_en ##1 pm_event_set);
	frame_irq_c: cover property (frame_ev ##[1:4] irq);

endmodule // wake_event_control

/* testbench/wake_event_control_tb_top.sv */
// Purpose: Self-checking bench of the wake-up event block
// Assumes: Straps held high; bench drives ports at rising edges
// Notes:   Link wait is bounded; a timeout ends the run
`timescale 1ns/1ns
`include "wake_defs.svh"

module wake_event_control_tb_top;
	import wake_pkg::*;

	logic                 clk_sys        = 1'b0;
	logic                 reset_n        = 1'b0;
	logic                 soft_reset     = 1'b0;
	logic                 link_up        = 1'b0;
	logic                 power_mgmt_cfg = 1'b1;
	logic                 wake_lan_cfg   = 1'b1;
	logic                 sig_packet_rx  = 1'b0;
	logic [4:0]           pattern_match  = 5'h00;
	bus_req_type          reg_req        = '0;
	logic [31:0]          reg_rdata;
	filter_type [4:0]     filters;
	logic [15:0]          crc_init_value;
	logic                 pm_event_set;
	logic                 irq;
	logic [31:0]          d;
	int                   n_fail         = 0;
	int                   n_checks       = 0;

	always #10 clk_sys = ~clk_sys;

	wake_event_control uut (
		.clk_sys        (clk_sys),
		.reset_n        (reset_n),
		.soft_reset     (soft_reset),
		.reg_req        (reg_req),
		.reg_rdata      (reg_rdata),
		.link_up        (link_up),
		.power_mgmt_cfg (power_mgmt_cfg),
		.wake_lan_cfg   (wake_lan_cfg),
		.sig_packet_rx  (sig_packet_rx),
		.pattern_match  (pattern_match),
		.filters        (filters),
		.crc_init_value (crc_init_value),
		.pm_event_set   (pm_event_set),
		.irq            (irq)
	);

	task automatic complete_run;
		if (n_fail == 0 && n_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
			n_fail++;
		end
	endtask

	function automatic logic [31:0] pw(input int k);
		return 32'hc300_0000 | (32'(k) << 16) | 32'(k);
	endfunction

	task automatic cycles(input int n);
		repeat (n) @(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_req <= '{a, v, 1'b1, 1'b0};
		@(posedge clk_sys);
		reg_req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
		@(posedge clk_sys);
		reg_req.rd <= 1'b0;
		#1 v = reg_rdata;
	endtask

	// Pulse events one cycle, return where their answer stands
	task automatic pulse_ev(input logic s, input logic [4:0] m);
		@(posedge clk_sys);
		sig_packet_rx <= s;
		pattern_match <= m;
		@(posedge clk_sys);
		sig_packet_rx <= 1'b0;
		pattern_match <= 5'h00;
		#1;
	endtask

	task automatic t_reset_vals;
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h0000_0200);
		rd(8'h6c, d);
		check(d, 32'h0000_0000);
	endtask

	task automatic t_patterns;
		logic [31:0] w;
		for (int k = 0; k < 25; k++) wr(`OFF_WAKE_PAT, pw(k));
		#1;
		for (int p = 0; p < 5; p++) begin
			w = pw(p*5 + 4);
			for (int j = 0; j < 4; j++) begin
				check(filters[p].mask[j*32 +: 32], pw(p*5 + j));
			end
			check({16'h0000, filters[p].crc}, {16'h0000, w[31:16]});
			check({24'h0, filters[p].start}, {24'h0, w[7:0]});
		end
		rd(`OFF_PAT_PTR, d);
		check(d, 32'h0000_0000);
		rd(`OFF_WAKE_PAT, d);
		check(d, pw(0));
	endtask

	task automatic t_crc;
		wr(`OFF_WAKE_CS, 32'h4000_0200);
		@(posedge clk_sys);
		#1 check({16'h0, crc_init_value}, 32'h0000_ffff);
		wr(`OFF_WAKE_CS, 32'h0000_0200);
		@(posedge clk_sys);
		#1 check({16'h0, crc_init_value}, 32'h0000_0000);
	endtask

	task automatic t_sig_irq;
		wr(`OFF_IRQ_MASK, 32'h0000_0002);
		pulse_ev(1'b1, 5'h00);
		check({31'h0, pm_event_set}, 32'h1);
		check({31'h0, irq}, 32'h1);
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h0000_0202);
		wr(`OFF_IRQ_STATUS, 32'h0000_0002);
		cycles(2);
		#1 check({31'h0, irq}, 32'h0);
		wr(`OFF_WAKE_CS, 32'h0000_0000);
		pulse_ev(1'b1, 5'h00);
		check({31'h0, pm_event_set}, 32'h0);
		check({31'h0, irq}, 32'h1);
		wr(`OFF_IRQ_STATUS, 32'h0000_0002);
	endtask

	task automatic t_link;
		int i;
		wr(`OFF_WAKE_CS, 32'h0001_0100);
		@(posedge clk_sys);
		link_up <= 1'b1;
		for (i = 0; i < 8 && pm_event_set !== 1'b1; i++) begin
			@(posedge clk_sys);
			#1;
		end
		if (pm_event_set !== 1'b1) begin
			n_fail++;
			complete_run();
		end
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h0001_0103);
		check({31'h0, irq}, 32'h0);
	endtask

	task automatic t_frame;
		wr(`OFF_WAKE_CS, 32'h2000_0400);
		pulse_ev(1'b0, 5'h02);
		check({31'h0, pm_event_set}, 32'h0);
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h2000_0403);
		pulse_ev(1'b0, 5'h01);
		check({31'h0, pm_event_set}, 32'h1);
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h2000_0407);
	endtask

	task automatic t_resets;
		@(posedge clk_sys);
		soft_reset <= 1'b1;
		@(posedge clk_sys);
		soft_reset <= 1'b0;
		cycles(5);
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h0000_0207);
		check(filters[0].mask[31:0], pw(0));
		wr(`OFF_WAKE_CS, 32'h0000_0007);
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h0000_0000);
		pulse_ev(1'b1, 5'h00);
		@(posedge clk_sys);
		reset_n <= 1'b0;
		cycles(2);
		reset_n <= 1'b1;
		cycles(5);
		rd(`OFF_WAKE_CS, d);
		check(d, 32'h0000_0200);
	endtask

	initial begin
		cycles(4);
		reset_n <= 1'b1;
		cycles(5);
		t_reset_vals();
		t_patterns();
		t_crc();
		t_sig_irq();
		t_link();
		t_frame();
		t_resets();
		complete_run();
	end

endmodule // wake_event_control_tb_top
